/* logic/scsi_wr_pkg.sv */
// Shared constants, register map and state encoding for the write command decoder
package scsi_wr_pkg;
	// ------------------------------------------------------------
	// Operation codes and descriptor layout
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_WRITE10 = 8'h2a;
	localparam logic [7:0] OPC_WR_VERIFY = 8'h2e;
	localparam logic [7:0] OPC_WR_LONG = 8'h3f;
	localparam int CDB_W = 80;
	localparam logic [3:0] CDB_LAST = 4'h9;
	localparam int OPC_LSB = 72;
	localparam int LBA_LSB = 32;
	localparam int LEN_LSB = 8;
	localparam int BYTCHK_BIT = 65;
	// ------------------------------------------------------------
	// Status bytes, sense keys and additional sense codes
	// ------------------------------------------------------------
	localparam logic [7:0] ST_GOOD = 8'h00;
	localparam logic [7:0] ST_CHECK = 8'h02;
	localparam logic [3:0] KEY_NONE = 4'h0;
	localparam logic [3:0] KEY_MEDIUM = 4'h3;
	localparam logic [3:0] KEY_ILLEGAL = 4'h5;
	localparam logic [3:0] KEY_MISCOMPARE = 4'he;
	localparam logic [7:0] ASC_NONE = 8'h00;
	localparam logic [7:0] ASC_RD_ERR = 8'h11;
	localparam logic [7:0] ASC_MISCMP = 8'h1d;
	localparam logic [7:0] ASC_BAD_OPC = 8'h20;
	localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
	// ------------------------------------------------------------
	// Register map, fields and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LONG_LEN = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_SENSE = 8'h0c;
	localparam logic [7:0] REG_INFO = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK = 8'h18;
	localparam logic [7:0] REG_BLKS = 8'h1c;
	localparam int CTRL_VERR_BIT = 0;
	localparam int STAT_OPC_LSB = 8;
	localparam int STAT_STS_LSB = 16;
	localparam int SNS_ASC_LSB = 8;
	localparam int SNS_VALID_BIT = 16;
	localparam int SNS_ILI_BIT = 17;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;
	localparam logic [15:0] LONG_LEN_RST = 16'h0210;
	localparam int BLK_BYTES_DEF = 512;
	// ------------------------------------------------------------
	// Command sequencer states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		S_CDB = 5'b00001,
		S_DEC = 5'b00010,
		S_XFER = 5'b00100,
		S_VRFY = 5'b01000,
		S_END = 5'b10000
	} state_e;
endpackage

/* logic/buf_if.sv */
// Port bundle between the sequencer and its block buffer
`timescale 1ns/1ps
interface buf_if #(
	parameter int AW = 9
) ();
	logic we;
	logic [AW-1:0] widx;
	logic [7:0] wbyte;
	logic [AW-1:0] ridx;
	logic [7:0] rbyte;
	modport user (output we, output widx, output wbyte, output ridx, input rbyte);
	modport mem (input we, input widx, input wbyte, input ridx, output rbyte);
endinterface

/* logic/blk_buf.sv */
// One-block byte buffer holding write data for the verify pass
`timescale 1ns/1ps
module blk_buf #(
	parameter int DEPTH = 512,
	parameter int AW = 9
) (
	input wire logic clk_i,
	buf_if.mem port_b
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] mem_ff [DEPTH];

	// Asynchronous read keeps compare aligned with the media byte
	always_ff @(posedge clk_i)
	begin
		if (port_b.we)
		begin
			mem_ff[port_b.widx] <= port_b.wbyte;
		end
	end

	assign port_b.rbyte = mem_ff[port_b.ridx];
endmodule // blk_buf

/* logic/scsi_write_cmd_decoder.sv */
// Write-class command decoder and executor with Wishbone registers
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module scsi_write_cmd_decoder #(
	parameter int BLK_BYTES = scsi_wr_pkg::BLK_BYTES_DEF,
	parameter logic [15:0] LONG_LEN_RST = scsi_wr_pkg::LONG_LEN_RST
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic cdb_valid_i,
	input wire logic [7:0] cdb_byte_i,
	output logic cdb_ready_o,
	input wire logic dat_valid_i,
	input wire logic [7:0] dat_byte_i,
	output logic dat_ready_o,
	input wire logic med_busy_i,
	output logic med_wr_o,
	output logic [31:0] med_lba_o,
	output logic [15:0] med_off_o,
	output logic [7:0] med_byte_o,
	output logic med_rd_o,
	input wire logic med_rd_valid_i,
	input wire logic [7:0] med_rd_byte_i,
	input wire logic med_rd_err_i,
	output logic done_o,
	output logic [7:0] status_o
);
	localparam int AW = $clog2(BLK_BYTES);
	localparam logic [15:0] BLK_LAST = 16'(BLK_BYTES - 1);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	scsi_wr_pkg::state_e state_ff, nxt_state;
	logic [scsi_wr_pkg::CDB_W-1:0] cdb_ff, nxt_cdb;
	logic [3:0] ccnt_ff, nxt_ccnt;
	logic wav_ff, nxt_wav;
	logic long_ff, nxt_long;
	logic [31:0] lba_ff, nxt_lba;
	logic [15:0] left_ff, nxt_left;
	logic [15:0] bcnt_ff, nxt_bcnt;
	logic [15:0] vcnt_ff, nxt_vcnt;
	logic [7:0] status_ff, nxt_status;
	logic [3:0] key_ff, nxt_key;
	logic [7:0] asc_ff, nxt_asc;
	logic svalid_ff, nxt_svalid;
	logic ili_ff, nxt_ili;
	logic [31:0] info_ff, nxt_info;
	logic [31:0] blks_ff, nxt_blks;
	logic med_wr_ff, nxt_med_wr;
	logic med_rd_ff, nxt_med_rd;
	logic [15:0] med_off_ff, nxt_med_off;
	logic [7:0] med_byte_ff, nxt_med_byte;
	logic done_ff, nxt_done;
	logic cdb_rdy_ff, nxt_cdb_rdy;
	logic dat_rdy_ff, nxt_dat_rdy;
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [15:0] long_len_ff, nxt_long_len;
	logic [1:0] irq_stat_ff, nxt_irq_stat;
	logic [1:0] irq_mask_ff, nxt_irq_mask;
	logic irq_ff, nxt_irq;
	logic ack_ff, nxt_ack;
	logic [31:0] rdat_ff, nxt_rdat;
	logic cdb_take;
	logic dat_take;
	logic bus_acc;
	logic [7:0] bus_adr;
	logic [7:0] cdb_opc;
	logic [31:0] cdb_lba;
	logic [15:0] cdb_len;
	logic cdb_bytchk;
	logic [16:0] resid;

	buf_if #(.AW(AW)) bufb ();

	blk_buf #(.DEPTH(BLK_BYTES), .AW(AW)) u_buf (
		.clk_i(clk_i),
		.port_b(bufb)
	);

	// ------------------------------------------------------------
	// Descriptor fields and handshakes
	// ------------------------------------------------------------
	assign cdb_opc = cdb_ff[scsi_wr_pkg::OPC_LSB +: 8];
	assign cdb_lba = cdb_ff[scsi_wr_pkg::LBA_LSB +: 32];
	assign cdb_len = cdb_ff[scsi_wr_pkg::LEN_LSB +: 16];
	assign cdb_bytchk = cdb_ff[scsi_wr_pkg::BYTCHK_BIT];
	assign cdb_take = cdb_valid_i && cdb_rdy_ff;
	assign dat_take = dat_valid_i && dat_rdy_ff;
	// Two's complement residue, requested minus actual
	assign resid = {1'h0, cdb_len} - {1'h0, long_len_ff};

	// Only verify-write keeps a copy, so the initiator is never asked twice
	assign bufb.we = dat_take && wav_ff;
	assign bufb.widx = bcnt_ff[AW-1:0];
	assign bufb.wbyte = dat_byte_i;
	assign bufb.ridx = vcnt_ff[AW-1:0];

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cdb = cdb_ff;
		nxt_ccnt = ccnt_ff;
		nxt_wav = wav_ff;
		nxt_long = long_ff;
		nxt_lba = lba_ff;
		nxt_left = left_ff;
		nxt_bcnt = bcnt_ff;
		nxt_vcnt = vcnt_ff;
		nxt_status = status_ff;
		nxt_key = key_ff;
		nxt_asc = asc_ff;
		nxt_svalid = svalid_ff;
		nxt_ili = ili_ff;
		nxt_info = info_ff;
		nxt_blks = blks_ff;
		nxt_med_wr = 1'h0;
		nxt_med_rd = 1'h0;
		nxt_med_off = med_off_ff;
		nxt_med_byte = med_byte_ff;
		nxt_done = 1'h0;
		case (state_ff)
			scsi_wr_pkg::S_CDB:
			begin
				if (cdb_take)
				begin
					nxt_cdb = {cdb_ff[scsi_wr_pkg::CDB_W-9:0], cdb_byte_i};
					nxt_ccnt = ccnt_ff + 4'h1;
					if (ccnt_ff == scsi_wr_pkg::CDB_LAST)
					begin
						nxt_ccnt = 4'h0;
						nxt_state = scsi_wr_pkg::S_DEC;
					end
				end
			end
			scsi_wr_pkg::S_DEC:
			begin
				nxt_status = scsi_wr_pkg::ST_GOOD;
				nxt_key = scsi_wr_pkg::KEY_NONE;
				nxt_asc = scsi_wr_pkg::ASC_NONE;
				nxt_svalid = 1'h0;
				nxt_ili = 1'h0;
				nxt_info = 32'h0;
				nxt_lba = cdb_lba;
				nxt_left = cdb_len;
				nxt_bcnt = 16'h0;
				nxt_vcnt = 16'h0;
				nxt_wav = (cdb_opc == scsi_wr_pkg::OPC_WR_VERIFY);
				nxt_long = (cdb_opc == scsi_wr_pkg::OPC_WR_LONG);
				nxt_state = scsi_wr_pkg::S_XFER;
				case (cdb_opc)
					scsi_wr_pkg::OPC_WRITE10, scsi_wr_pkg::OPC_WR_VERIFY:
					begin
						if (cdb_len == 16'h0)
						begin
							nxt_state = scsi_wr_pkg::S_END;
						end
					end
					scsi_wr_pkg::OPC_WR_LONG:
					begin
						if (cdb_len == 16'h0)
						begin
							nxt_state = scsi_wr_pkg::S_END;
						end
						else if (cdb_len != long_len_ff)
						begin
							nxt_status = scsi_wr_pkg::ST_CHECK;
							nxt_key = scsi_wr_pkg::KEY_ILLEGAL;
							nxt_asc = scsi_wr_pkg::ASC_BAD_FIELD;
							nxt_svalid = 1'h1;
							nxt_ili = 1'h1;
							nxt_info = {{15{resid[16]}}, resid};
							nxt_state = scsi_wr_pkg::S_END;
						end
					end
					default:
					begin
						nxt_status = scsi_wr_pkg::ST_CHECK;
						nxt_key = scsi_wr_pkg::KEY_ILLEGAL;
						nxt_asc = scsi_wr_pkg::ASC_BAD_OPC;
						nxt_state = scsi_wr_pkg::S_END;
					end
				endcase
			end
			scsi_wr_pkg::S_XFER:
			begin
				if (dat_take)
				begin
					nxt_med_wr = 1'h1;
					nxt_med_byte = dat_byte_i;
					nxt_med_off = bcnt_ff;
					nxt_bcnt = bcnt_ff + 16'h1;
					if (long_ff)
					begin
						// Data and ECC bytes alike go to the medium untouched
						if (bcnt_ff == cdb_len - 16'h1)
						begin
							nxt_state = scsi_wr_pkg::S_END;
						end
					end
					else if (bcnt_ff == BLK_LAST)
					begin
						nxt_bcnt = 16'h0;
						nxt_blks = blks_ff + 32'h1;
						if (wav_ff)
						begin
							nxt_med_rd = 1'h1;
							nxt_vcnt = 16'h0;
							nxt_state = scsi_wr_pkg::S_VRFY;
						end
						else
						begin
							nxt_left = left_ff - 16'h1;
							if (left_ff == 16'h1)
							begin
								nxt_state = scsi_wr_pkg::S_END;
							end
						end
					end
				end
			end
			scsi_wr_pkg::S_VRFY:
			begin
				if (med_rd_valid_i)
				begin
					nxt_vcnt = vcnt_ff + 16'h1;
					if (med_rd_err_i && ctrl_ff[scsi_wr_pkg::CTRL_VERR_BIT])
					begin
						nxt_status = scsi_wr_pkg::ST_CHECK;
						nxt_key = scsi_wr_pkg::KEY_MEDIUM;
						nxt_asc = scsi_wr_pkg::ASC_RD_ERR;
						nxt_state = scsi_wr_pkg::S_END;
					end
					else if (cdb_bytchk && (med_rd_byte_i != bufb.rbyte))
					begin
						nxt_status = scsi_wr_pkg::ST_CHECK;
						nxt_key = scsi_wr_pkg::KEY_MISCOMPARE;
						nxt_asc = scsi_wr_pkg::ASC_MISCMP;
						nxt_state = scsi_wr_pkg::S_END;
					end
					else if (vcnt_ff == BLK_LAST)
					begin
						nxt_vcnt = 16'h0;
						nxt_lba = lba_ff + 32'h1;
						nxt_left = left_ff - 16'h1;
						if (left_ff == 16'h1)
						begin
							nxt_state = scsi_wr_pkg::S_END;
						end
						else
						begin
							nxt_state = scsi_wr_pkg::S_XFER;
						end
					end
				end
			end
			scsi_wr_pkg::S_END:
			begin
				nxt_done = 1'h1;
				nxt_state = scsi_wr_pkg::S_CDB;
			end
			default:
			begin
				nxt_state = scsi_wr_pkg::S_CDB;
			end
		endcase
		// Address steps after the last byte left, so that byte keeps its own block
		if (med_wr_ff && !long_ff && !wav_ff && (med_off_ff == BLK_LAST))
		begin
			nxt_lba = lba_ff + 32'h1;
		end
		nxt_cdb_rdy = (nxt_state == scsi_wr_pkg::S_CDB);
		// Ready drops after each byte so a busy medium can stall the initiator
		nxt_dat_rdy = (nxt_state == scsi_wr_pkg::S_XFER) && !dat_take && !med_busy_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_ff <= scsi_wr_pkg::S_CDB;
			cdb_ff <= 80'h0;
			ccnt_ff <= 4'h0;
			wav_ff <= 1'h0;
			long_ff <= 1'h0;
			lba_ff <= 32'h0;
			left_ff <= 16'h0;
			bcnt_ff <= 16'h0;
			vcnt_ff <= 16'h0;
			status_ff <= scsi_wr_pkg::ST_GOOD;
			key_ff <= scsi_wr_pkg::KEY_NONE;
			asc_ff <= scsi_wr_pkg::ASC_NONE;
			svalid_ff <= 1'h0;
			ili_ff <= 1'h0;
			info_ff <= 32'h0;
			blks_ff <= 32'h0;
			med_wr_ff <= 1'h0;
			med_rd_ff <= 1'h0;
			med_off_ff <= 16'h0;
			med_byte_ff <= 8'h0;
			done_ff <= 1'h0;
			cdb_rdy_ff <= 1'h0;
			dat_rdy_ff <= 1'h0;
		end
		else
		begin
			state_ff <= nxt_state;
			cdb_ff <= nxt_cdb;
			ccnt_ff <= nxt_ccnt;
			wav_ff <= nxt_wav;
			long_ff <= nxt_long;
			lba_ff <= nxt_lba;
			left_ff <= nxt_left;
			bcnt_ff <= nxt_bcnt;
			vcnt_ff <= nxt_vcnt;
			status_ff <= nxt_status;
			key_ff <= nxt_key;
			asc_ff <= nxt_asc;
			svalid_ff <= nxt_svalid;
			ili_ff <= nxt_ili;
			info_ff <= nxt_info;
			blks_ff <= nxt_blks;
			med_wr_ff <= nxt_med_wr;
			med_rd_ff <= nxt_med_rd;
			med_off_ff <= nxt_med_off;
			med_byte_ff <= nxt_med_byte;
			done_ff <= nxt_done;
			cdb_rdy_ff <= nxt_cdb_rdy;
			dat_rdy_ff <= nxt_dat_rdy;
		end
	end

	// ------------------------------------------------------------
	// Wishbone registers and interrupt
	// ------------------------------------------------------------
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] din,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[8*i +: 8] = din[8*i +: 8];
			end
		end
		return r;
	endfunction

	assign bus_acc = wb_cyc_i && wb_stb_i && !ack_ff;
	assign bus_adr = {wb_adr_i[7:2], 2'h0};

	always_comb
	begin
		nxt_ack = bus_acc;
		nxt_rdat = 32'h0;
		nxt_ctrl = ctrl_ff;
		nxt_long_len = long_len_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_irq_stat = irq_stat_ff;
		if (bus_acc && wb_we_i)
		begin
			case (bus_adr)
				scsi_wr_pkg::REG_CTRL:
					nxt_ctrl = wmerge(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_0001;
				scsi_wr_pkg::REG_LONG_LEN:
					nxt_long_len = 16'(wmerge({16'h0, long_len_ff}, wb_dat_i, wb_sel_i));
				scsi_wr_pkg::REG_IRQ_MASK:
					nxt_irq_mask = 2'(wmerge({30'h0, irq_mask_ff}, wb_dat_i, wb_sel_i));
				default:
					nxt_rdat = 32'h0;
			endcase
		end
		if (bus_acc && !wb_we_i)
		begin
			case (bus_adr)
				scsi_wr_pkg::REG_CTRL: nxt_rdat = ctrl_ff;
				scsi_wr_pkg::REG_LONG_LEN: nxt_rdat = {16'h0, long_len_ff};
				scsi_wr_pkg::REG_STATUS: nxt_rdat = {8'h0, status_ff, cdb_opc, 7'h0,
					(state_ff != scsi_wr_pkg::S_CDB)};
				scsi_wr_pkg::REG_SENSE: nxt_rdat = {14'h0, ili_ff, svalid_ff, asc_ff, 4'h0, key_ff};
				scsi_wr_pkg::REG_INFO: nxt_rdat = info_ff;
				scsi_wr_pkg::REG_IRQ_STAT: nxt_rdat = {30'h0, irq_stat_ff};
				scsi_wr_pkg::REG_IRQ_MASK: nxt_rdat = {30'h0, irq_mask_ff};
				scsi_wr_pkg::REG_BLKS: nxt_rdat = blks_ff;
				default: nxt_rdat = 32'h0;
			endcase
			if (bus_adr == scsi_wr_pkg::REG_IRQ_STAT)
			begin
				nxt_irq_stat = 2'h0;
			end
		end
		// Events land after the read clear, so one arriving with it survives
		if (state_ff == scsi_wr_pkg::S_END)
		begin
			nxt_irq_stat[scsi_wr_pkg::IRQ_DONE_BIT] = 1'h1;
			if (status_ff != scsi_wr_pkg::ST_GOOD)
			begin
				nxt_irq_stat[scsi_wr_pkg::IRQ_ERR_BIT] = 1'h1;
			end
		end
		nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'h0;
			rdat_ff <= 32'h0;
			ctrl_ff <= scsi_wr_pkg::RST_CTRL;
			long_len_ff <= LONG_LEN_RST;
			irq_mask_ff <= scsi_wr_pkg::RST_IRQ_MASK;
			irq_stat_ff <= 2'h0;
			irq_ff <= 1'h0;
		end
		else
		begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
			ctrl_ff <= nxt_ctrl;
			long_len_ff <= nxt_long_len;
			irq_mask_ff <= nxt_irq_mask;
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= nxt_irq;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign irq_o = irq_ff;
	assign cdb_ready_o = cdb_rdy_ff;
	assign dat_ready_o = dat_rdy_ff;
	assign med_wr_o = med_wr_ff;
	assign med_rd_o = med_rd_ff;
	assign med_lba_o = lba_ff;
	assign med_off_o = med_off_ff;
	assign med_byte_o = med_byte_ff;
	assign done_o = done_ff;
	assign status_o = status_ff;
endmodule // scsi_write_cmd_decoder

/* verif/wr_checker.sv */
// Port assertions for the write command decoder
`timescale 1ns/1ps
module wr_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic cdb_ready_o,
	input wire logic dat_valid_i,
	input wire logic [7:0] dat_byte_i,
	input wire logic dat_ready_o,
	input wire logic med_busy_i,
	input wire logic med_wr_o,
	input wire logic [7:0] med_byte_o,
	input wire logic med_rd_o,
	input wire logic irq_o,
	input wire logic done_o,
	input wire logic [7:0] status_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// Bus and stream relations
	// ------------------------------------------------------------
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_write_follows: assert property (dat_valid_i && dat_ready_o |=>
		med_wr_o && med_byte_o == $past(dat_byte_i))
		else $error("taken byte not written next cycle");
	a_write_cause: assert property (med_wr_o |-> $past(dat_valid_i && dat_ready_o))
		else $error("medium write without taken byte");
	a_ready_gap: assert property (dat_valid_i && dat_ready_o |=> !dat_ready_o)
		else $error("data ready not dropped after take");
	a_busy_holds: assert property (med_busy_i |=> !dat_ready_o)
		else $error("data ready while medium busy");
	a_verify_last: assert property (med_rd_o |-> med_wr_o)
		else $error("read-back not at last block write");
	a_no_cdb_in_data: assert property (dat_ready_o |-> !cdb_ready_o)
		else $error("descriptor intake during data phase");
	a_done_pulse: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_done_status: assert property (done_o |-> status_o inside {8'h00, 8'h02})
		else $error("bad status byte");
	c_check_end: cover property (done_o && status_o == 8'h02);
	c_good_end: cover property (done_o && status_o == 8'h00);
	c_read_back: cover property (med_rd_o);
	c_irq: cover property (irq_o);
endmodule // wr_checker

/* verif/med_model.sv */
// Behavioural medium: stores 64 bytes by offset, answers verify read-backs
`timescale 1ns/1ps
module med_model #(
	parameter int BLK_BYTES = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic flip_i,
	input wire logic err_i,
	input wire logic stall_i,
	input wire logic wr_i,
	input wire logic [15:0] off_i,
	input wire logic [7:0] byte_i,
	input wire logic rd_i,
	output logic busy_o,
	output logic rd_valid_o,
	output logic [7:0] rd_byte_o,
	output logic rd_err_o
);
	logic [7:0] mem [0:63];
	int left;
	int idx;
	int tick;
	always @(posedge clk_i)
	begin
		tick <= tick + 1;
		busy_o <= stall_i && (tick % 8 < 3);
		rd_valid_o <= 1'b0;
		rd_err_o <= 1'b0;
		// Idle data line toggles so a stale byte never looks valid
		rd_byte_o <= ~rd_byte_o;
		if (wr_i)
			mem[off_i[5:0]] <= byte_i;
		if (rst_i)
		begin
			left <= 0;
			rd_byte_o <= 8'h5a;
		end
		else if (rd_i)
		begin
			left <= BLK_BYTES;
			idx <= 0;
		end
		else if (left > 0 && !(stall_i && tick[0]))
		begin
			rd_valid_o <= 1'b1;
			rd_byte_o <= mem[idx] ^ {7'h0, flip_i && idx == 1};
			rd_err_o <= err_i && idx == 0;
			left <= left - 1;
			idx <= idx + 1;
		end
	end
endmodule // med_model

/* verif/tb.sv */
// Self-checking bench for the write command decoder
`timescale 1ns/1ps
module tb;
	localparam int BB = 4;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, med_lba_o;
	logic cdb_valid_i, cdb_ready_o, dat_valid_i, dat_ready_o, med_busy_i, med_wr_o;
	logic [7:0] cdb_byte_i, dat_byte_i, med_byte_o, med_rd_byte_i, status_o;
	logic [15:0] med_off_o;
	logic med_rd_o, med_rd_valid_i, med_rd_err_i, done_o, flip, err, stall;
	logic [31:0] exp_rd_q [$];
	logic [7:0] exp_sts_q [$];
	logic [55:0] exp_wr_q [$];
	logic [7:0] opcs [3] = '{scsi_wr_pkg::OPC_WRITE10, scsi_wr_pkg::OPC_WR_VERIFY,
		scsi_wr_pkg::OPC_WR_LONG};
	int fail_count, num_checks, rd_cnt, cycles;
	scsi_write_cmd_decoder #(.BLK_BYTES(BB), .LONG_LEN_RST(16'h0010)) dut_u (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .irq_o(irq_o), .cdb_valid_i(cdb_valid_i), .cdb_byte_i(cdb_byte_i),
		.cdb_ready_o(cdb_ready_o), .dat_valid_i(dat_valid_i), .dat_byte_i(dat_byte_i),
		.dat_ready_o(dat_ready_o), .med_busy_i(med_busy_i), .med_wr_o(med_wr_o),
		.med_lba_o(med_lba_o), .med_off_o(med_off_o), .med_byte_o(med_byte_o),
		.med_rd_o(med_rd_o), .med_rd_valid_i(med_rd_valid_i), .med_rd_byte_i(med_rd_byte_i),
		.med_rd_err_i(med_rd_err_i), .done_o(done_o), .status_o(status_o));
	med_model #(.BLK_BYTES(BB)) med_u (.clk_i(clk_i), .rst_i(rst_i), .flip_i(flip),
		.err_i(err), .stall_i(stall), .wr_i(med_wr_o), .off_i(med_off_o),
		.byte_i(med_byte_o), .rd_i(med_rd_o), .busy_o(med_busy_i),
		.rd_valid_o(med_rd_valid_i), .rd_byte_o(med_rd_byte_i), .rd_err_o(med_rd_err_i));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] e);
		if (!we)
			exp_rd_q.push_back(e);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (!wb_ack_o);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// Initiator: descriptor, then data until the command ends
	task automatic cmd(input logic [7:0] opc, input logic [7:0] b1, input logic [15:0] len,
		input int nb, input logic [7:0] sts);
		logic [31:0] lba;
		logic [7:0] cdb [10];
		int i;
		lba = $urandom;
		cdb = '{opc, b1, lba[31:24], lba[23:16], lba[15:8], lba[7:0], 8'h00, len[15:8],
			len[7:0], 8'h00};
		exp_sts_q.push_back(sts);
		for (i = 0; i < 10; i++)
		begin
			cdb_valid_i <= 1'b1;
			cdb_byte_i <= cdb[i];
			do @(posedge clk_i); while (!cdb_ready_o);
		end
		cdb_valid_i <= 1'b0;
		dat_byte_i <= 8'($urandom);
		i = 0;
		while (!done_o)
		begin
			dat_valid_i <= i < nb;
			@(posedge clk_i);
			if (dat_valid_i && dat_ready_o)
			begin
				// Long data stays at one block address, offsets run over the whole length
				exp_wr_q.push_back(opc == scsi_wr_pkg::OPC_WR_LONG ? {lba, 16'(i), dat_byte_i} :
					{lba + 32'(i / BB), 16'(i % BB), dat_byte_i});
				i++;
				dat_byte_i <= 8'($urandom);
			end
		end
		dat_valid_i <= 1'b0;
		$display("test cmd %h len %0d done", opc, len);
	endtask
	// ------------------------------------------------------------
	// Result watcher and timeout
	// ------------------------------------------------------------
	always @(posedge clk_i)
	begin
		if (wb_ack_o && !wb_we_i)
			chk(wb_dat_o, exp_rd_q.size() ? exp_rd_q.pop_front() : 'x);
		if (done_o)
			chk(status_o, exp_sts_q.size() ? exp_sts_q.pop_front() : 'x);
		if (med_wr_o)
			chk({med_lba_o, med_off_o, med_byte_o},
				exp_wr_q.size() ? exp_wr_q.pop_front() : 'x);
		if (med_rd_o)
			rd_cnt++;
		cycles++;
		// Ceiling well above the roughly 500 cycles the sequence needs
		if (cycles == 30000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{wb_cyc_i, wb_stb_i, wb_we_i, cdb_valid_i, dat_valid_i, flip, err, stall} = '0;
		{wb_adr_i, wb_dat_i, cdb_byte_i, dat_byte_i} = '0;
		wb_sel_i = 4'hf;
		rst_i = 1'b1;
		void'($urandom(32'h6073));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, scsi_wr_pkg::REG_CTRL, 0, 0);
		wb(0, scsi_wr_pkg::REG_LONG_LEN, 0, 32'h10);
		wb(0, scsi_wr_pkg::REG_IRQ_MASK, 0, 0);
		wb(0, 8'h20, 32'hffff_ffff, 0);
		foreach (opcs[k])
			cmd(opcs[k], 8'h02, 16'h0, 0, scsi_wr_pkg::ST_GOOD);
		wb(0, scsi_wr_pkg::REG_BLKS, 0, 0);
		stall <= 1'b1;
		cmd(scsi_wr_pkg::OPC_WRITE10, 8'h00, 16'd3, 3 * BB, scsi_wr_pkg::ST_GOOD);
		wb(0, scsi_wr_pkg::REG_BLKS, 0, 3);
		flip <= 1'b1;
		rd_cnt = 0;
		cmd(scsi_wr_pkg::OPC_WR_VERIFY, 8'h00, 16'd2, 2 * BB, scsi_wr_pkg::ST_GOOD);
		chk(rd_cnt, 2);
		cmd(scsi_wr_pkg::OPC_WR_VERIFY, 8'h02, 16'd2, 2 * BB, scsi_wr_pkg::ST_CHECK);
		wb(0, scsi_wr_pkg::REG_SENSE, 0, 32'h0000_1d0e);
		flip <= 1'b0;
		cmd(scsi_wr_pkg::OPC_WR_VERIFY, 8'h02, 16'd2, 2 * BB, scsi_wr_pkg::ST_GOOD);
		wb(1, scsi_wr_pkg::REG_CTRL, 1, 0);
		err <= 1'b1;
		cmd(scsi_wr_pkg::OPC_WR_VERIFY, 8'h00, 16'd1, BB, scsi_wr_pkg::ST_CHECK);
		wb(0, scsi_wr_pkg::REG_SENSE, 0, 32'h0000_1103);
		err <= 1'b0;
		cmd(scsi_wr_pkg::OPC_WR_LONG, 8'h00, 16'd12, 12, scsi_wr_pkg::ST_CHECK);
		wb(0, scsi_wr_pkg::REG_SENSE, 0, 32'h0003_2405);
		wb(0, scsi_wr_pkg::REG_INFO, 0, 32'hffff_fffc);
		cmd(scsi_wr_pkg::OPC_WR_LONG, 8'h00, 16'd20, 20, scsi_wr_pkg::ST_CHECK);
		wb(0, scsi_wr_pkg::REG_INFO, 0, 32'h0000_0004);
		cmd(scsi_wr_pkg::OPC_WR_LONG, 8'h00, 16'd16, 16, scsi_wr_pkg::ST_GOOD);
		cmd(8'h28, 8'h00, 16'd1, BB, scsi_wr_pkg::ST_CHECK);
		wb(0, scsi_wr_pkg::REG_STATUS, 0, 32'h0002_2800);
		wb(0, scsi_wr_pkg::REG_SENSE, 0, 32'h0000_2005);
		wb(0, scsi_wr_pkg::REG_IRQ_STAT, 0, 3);
		wb(1, scsi_wr_pkg::REG_IRQ_MASK, 1, 0);
		cmd(scsi_wr_pkg::OPC_WRITE10, 8'h00, 16'd1, BB, scsi_wr_pkg::ST_GOOD);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 1);
		wb(0, scsi_wr_pkg::REG_IRQ_STAT, 0, 1);
		@(posedge clk_i);
		chk(irq_o, 0);
		wb(1, scsi_wr_pkg::REG_IRQ_MASK, 2, 0);
		cmd(scsi_wr_pkg::OPC_WRITE10, 8'h00, 16'd1, BB, scsi_wr_pkg::ST_GOOD);
		repeat (3) @(posedge clk_i);
		chk(irq_o, 0);
		$display("test interrupts done");
		tally_and_finish();
	end
endmodule // tb
bind scsi_write_cmd_decoder wr_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cdb_ready_o(cdb_ready_o),
	.dat_valid_i(dat_valid_i), .dat_byte_i(dat_byte_i), .dat_ready_o(dat_ready_o),
	.med_busy_i(med_busy_i), .med_wr_o(med_wr_o), .med_byte_o(med_byte_o),
	.med_rd_o(med_rd_o), .irq_o(irq_o), .done_o(done_o), .status_o(status_o));
